// ==== adc_cal_and_jesd_transport.sv ====
// Channel output path: calibration control, sample format and JESD204B transport framing
//
// Behaviour
// - After valid supplies and clock, wait the power-up delay, then calibrate automatically.
// - A core calibration run lasts about two million sampling clock cycles.
// - Power-down then return to normal operation starts a manual calibration.
// - Calibration-complete flag is readable in the link status register.
// - Two's complement by default, offset binary optional, applied before framing.
// - Subclass 1 or 0 only; subclass 2 is not available.
// - SYSREF may be periodic, pulsed periodic or a single pulse.
// - Deterministic latency only in subclass 1 with a standard SYSREF.
// - No lane polarity inversion; lanes meant for AC coupling.
// - Only lane count, K and scrambling are configurable; F and HD follow lanes.
// - No idle link mode and no transport layer test patterns.
// - 8b/10b data link with D21.5, K28.5, ILA, PRBS7, PRBS23, ramp tests.
// - Each channel uses one or two lanes of its own, never shared.
// - Single lane carries twenty bits per sample.
// - Dual lane carries ten bits per sample on each lane.
// - One converter per link; lane count counts this channel's lanes.
// - Resolution, bits per sample, control bits and words, M, S are fixed.
// - Single lane: two octets per frame, HD off; dual: one octet, HD on.
// - K limited to 9..32 single lane and 17..32 dual lane.
// - Scrambling off by default; alignment data never scrambled.
// - Counting link parameters are reported as value minus one.
`timescale 1ns/1ps
`include "adc_link_consts.svh"
module adc_cal_and_jesd_transport #(
  parameter int POR_CYCLES = `POR_CYCLES,
  parameter int CAL_CYCLES = `CAL_CYCLES,
  parameter int RES        = `RESOLUTION
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // Register port
  input  wire adc_link_pkg::addr_t reg_addr,
  input  wire adc_link_pkg::word_t reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output      adc_link_pkg::word_t reg_rdata,
  // Converter side
  input  wire logic                clk_ok,
  input  wire logic [RES-1:0]      sample_in,
  input  wire logic                sample_valid,
  input  wire logic                sysref,
  // Lane side
  output      logic [7:0]          lane0_data,
  output      logic [7:0]          lane1_data,
  output      logic [1:0]          lane_k,
  output      logic [1:0]          lane_valid,
  output      logic                frame_end,
  output      logic                multiframe_end,
  output      logic [1:0]          clock_divide_factor
);
  import adc_link_pkg::*;

  // ==========================================
  // Bit-serial helpers
  // Self-synchronous scrambler 1 + x^14 + x^15, MSB first
  function automatic logic [22:0] scr8(input logic [7:0] d, input logic [14:0] s);
    logic [14:0] r;
    logic [7:0]  o;
    r = s;
    o = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      o[i] = d[i] ^ r[14] ^ r[13];
      r    = {r[13:0], o[i]};
    end
    return {r, o};
  endfunction : scr8

  // PRBS7 (x^7+x^6+1) or PRBS23 (x^23+x^18+1), sixteen bits a step
  function automatic logic [38:0] prbs16(input logic [22:0] s, input logic long);
    logic [22:0] r;
    logic [15:0] o;
    logic        fb;
    r = s;
    o = 16'h0000;
    for (int i = 15; i >= 0; i--) begin
      fb   = long ? (r[22] ^ r[17]) : (r[6] ^ r[5]);
      r    = {r[21:0], fb};
      o[i] = fb;
    end
    return {r, o};
  endfunction : prbs16

  // ==========================================
  // Registers
  logic [9:0]  ctrl_q;
  logic [5:0]  k_q;
  logic [15:0] ramp_step_q;
  word_t       rdata_q;

  cal_if cal ();

  cal_seq #(
    .POR_CYCLES (POR_CYCLES),
    .CAL_CYCLES (CAL_CYCLES)
  ) u_cal (
    .clk   (clk),
    .rst_n (rst_n),
    .cal   (cal.seq)
  );

  wire        pd      = ctrl_q[`CTRL_PD];
  wire        offbin  = ctrl_q[`CTRL_OFFBIN];
  wire        dual    = ctrl_q[`CTRL_DUAL];
  wire        scr_en  = ctrl_q[`CTRL_SCR];
  wire        sc1     = ctrl_q[`CTRL_SC1];
  wire [2:0]  tm_raw  = ctrl_q[`CTRL_TM_HI:`CTRL_TM_LO];
  // Unused codes fall back to normal data; no idle or transport test modes exist
  wire        tm_ok   = (tm_raw <= 3'h6);
  test_mode_e tmode;
  assign tmode = tm_ok ? test_mode_e'(tm_raw) : TM_NORMAL;

  assign cal.power_down = pd;
  assign cal.clk_ok     = clk_ok;

  // K is held inside the range the lane mode allows
  wire [5:0] k_min = dual ? `K_MIN_DUAL : `K_MIN_SINGLE;
  wire [5:0] k_eff = (k_q < k_min) ? k_min : (k_q > `K_MAX) ? `K_MAX : k_q;
  wire [5:0] k_last = k_eff - 6'h01;

  // Link parameters as value minus one; F, L follow the lane mode only
  wire [4:0] f_m1 = dual ? 5'h00 : 5'h01;
  wire [4:0] l_m1 = dual ? 5'h01 : 5'h00;
  wire [4:0] n_m1 = 5'(RES - 1);
  wire [31:0] params_word = {1'b0, dual, 5'h00, n_m1, n_m1, k_last[4:0], l_m1, f_m1};

  wire sel_ctrl   = (reg_addr == `ADDR_CTRL);
  wire sel_kcfg   = (reg_addr == `ADDR_KCFG);
  wire sel_status = (reg_addr == `ADDR_STATUS);
  wire sel_params = (reg_addr == `ADDR_PARAMS);
  wire sel_ramp   = (reg_addr == `ADDR_RAMP);

  wire [31:0] status_word = {29'h0, cal.por_wait, cal.cal_busy, cal.cal_done};
  wire [31:0] rd_mux =
    sel_ctrl   ? {22'h0, ctrl_q} :
    sel_kcfg   ? {26'h0, k_eff} :
    sel_status ? status_word :
    sel_params ? params_word :
    sel_ramp   ? {16'h0, ramp_step_q} : 32'h0;

  // Subclass 2 cannot be requested: a single bit picks subclass 1 or 0
  wire [9:0] ctrl_wr = reg_wdata[9:0];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q      <= `CTRL_RST;
      k_q         <= `KCFG_RST;
      ramp_step_q <= `RAMP_RST;
      rdata_q     <= 32'h0;
    end else begin
      if (reg_wr && sel_ctrl) ctrl_q <= ctrl_wr;
      if (reg_wr && sel_kcfg) k_q <= reg_wdata[5:0];
      if (reg_wr && sel_ramp) ramp_step_q <= reg_wdata[15:0];
      rdata_q <= reg_rd ? rd_mux : 32'h0;
    end
  end

  // ==========================================
  // Transport framing
  logic        oct_q;
  logic [7:0]  pend_q;
  logic        pendk_q;
  logic [5:0]  fc_q;
  logic        sr_q;
  logic [15:0] ramp_q;
  logic [22:0] prbs_q;
  logic [14:0] sst_q [2];

  // In single lane a frame spans two cycles, so a new one waits for the second octet;
  // a pending second octet also goes out first across a lane mode change
  wire slot_free = !oct_q;
  wire start     = !pd && slot_free && ((tmode == TM_NORMAL) ? sample_valid : 1'b1);
  // Any SYSREF shape works: in subclass 1 its rising edge alone realigns the multiframe
  wire sr_rise   = sysref && !sr_q && sc1;
  wire fr_end    = (dual && start) || (!pd && oct_q);
  // Lowering K mid-multiframe ends it at the next frame end instead of wrapping the counter
  wire mf_end    = fr_end && (fc_q >= k_last);

  wire [15:0] fmt_sample = offbin ? (sample_in ^ `SIGN_FLIP) : sample_in;
  wire [38:0] prbs_nx    = prbs16(prbs_q, tmode == TM_PRBS23);
  wire        ila_first  = (fc_q == 6'h00);
  wire        ila_last   = (fc_q == k_last);

  logic [15:0] word_d;
  logic [1:0]  kw_d;
  always_comb begin
    kw_d = 2'b00;
    case (tmode)
      TM_NORMAL: word_d = fmt_sample;
      TM_RAMP:   word_d = ramp_q;
      TM_D21_5:  word_d = {`OCT_D21_5, `OCT_D21_5};
      TM_K28_5: begin
        word_d = {`OCT_K28_5, `OCT_K28_5};
        kw_d   = 2'b11;
      end
      TM_ILA: begin
        word_d = {ila_first ? `OCT_K28_0 : 8'h00, ila_last ? `OCT_K28_3 : 8'h00};
        kw_d   = {ila_first, ila_last};
      end
      TM_PRBS7, TM_PRBS23: word_d = prbs_nx[15:0];
      default:   word_d = fmt_sample;
    endcase
  end

  // Per-lane octet selection: upper octet first / on lane 0
  wire [7:0] raw  [2];
  wire       rk   [2];
  wire       em   [2];
  assign raw[0] = start ? word_d[15:8] : pend_q;
  assign rk[0]  = start ? kw_d[1] : pendk_q;
  assign em[0]  = start || (oct_q && !pd);
  assign raw[1] = word_d[7:0];
  assign rk[1]  = kw_d[0];
  assign em[1]  = start && dual;

  // Test patterns other than the ramp stay plain so the receiver can check them directly
  wire scr_mode = scr_en && (tmode == TM_NORMAL || tmode == TM_RAMP);
  wire [7:0]  lane_o [2];
  wire [14:0] sst_nx [2];

  genvar l;
  generate
    for (l = 0; l < 2; l++) begin : g_lane
      wire [22:0] s8 = scr8(raw[l], sst_q[l]);
      wire        on = scr_mode && !rk[l];
      assign lane_o[l] = on ? s8[7:0] : raw[l];
      assign sst_nx[l] = (em[l] && on) ? s8[22:8] : sst_q[l];
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      oct_q          <= 1'b0;
      pend_q         <= 8'h00;
      pendk_q        <= 1'b0;
      fc_q           <= 6'h00;
      sr_q           <= 1'b0;
      ramp_q         <= 16'h0000;
      prbs_q         <= `PRBS_SEED;
      sst_q[0]       <= `SCR_SEED;
      sst_q[1]       <= `SCR_SEED;
      lane0_data     <= 8'h00;
      lane1_data     <= 8'h00;
      lane_k         <= 2'b00;
      lane_valid     <= 2'b00;
      frame_end      <= 1'b0;
      multiframe_end <= 1'b0;
    end else begin
      sr_q     <= sysref;
      sst_q[0] <= sst_nx[0];
      sst_q[1] <= sst_nx[1];
      if (sr_rise) begin
        fc_q  <= 6'h00;
        oct_q <= 1'b0;
      end else begin
        if (fr_end) fc_q <= mf_end ? 6'h00 : fc_q + 6'h01;
        if (!dual && start) oct_q <= 1'b1;
        else if (oct_q) oct_q <= 1'b0;
      end
      if (start) begin
        pend_q  <= word_d[7:0];
        pendk_q <= kw_d[0];
        if (tmode == TM_RAMP) ramp_q <= ramp_q + ramp_step_q;
        if (tmode == TM_PRBS7 || tmode == TM_PRBS23) prbs_q <= prbs_nx[38:16];
      end
      lane0_data     <= lane_o[0];
      lane1_data     <= em[1] ? lane_o[1] : 8'h00;
      lane_k         <= {em[1] && rk[1], em[0] && rk[0]};
      lane_valid     <= {em[1], em[0]};
      frame_end      <= fr_end;
      multiframe_end <= mf_end;
    end
  end

  assign reg_rdata           = rdata_q;
  assign clock_divide_factor = ctrl_q[`CTRL_DIV_HI:`CTRL_DIV_LO];

  // ==========================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_status;
    (reg_rd && reg_addr == `ADDR_STATUS) |=> (reg_rdata[0] == $past(cal.cal_done));
  endproperty
  a_status: assert property (p_status) else $error("status flag readback wrong");

  property p_offset;
    (start && dual && tmode == TM_NORMAL && !scr_en)
      |=> ({lane0_data, lane1_data} == ($past(sample_in) ^ ($past(offbin) ? 16'h8000 : 16'h0)));
  endproperty
  a_offset: assert property (p_offset) else $error("sample format wrong");

  sequence s_two_octets(logic [15:0] w);
    (lane_valid == 2'b01 && lane0_data == w[15:8]) ##1
    (lane_valid == 2'b01 && lane0_data == w[7:0]);
  endsequence

  property p_single;
    logic [15:0] w;
    (start && !dual && !scr_mode && !sr_rise && tmode != TM_ILA, w = word_d)
      |=> s_two_octets(w);
  endproperty
  a_single: assert property (p_single) else $error("single lane octet order wrong");

  property p_k_range;
    dual ? (k_eff >= 6'h11 && k_eff <= 6'h20) : (k_eff >= 6'h09 && k_eff <= 6'h20);
  endproperty
  a_k_range: assert property (p_k_range) else $error("K out of range");

  property p_cfg;
    (reg_rd && reg_addr == `ADDR_PARAMS)
      |=> (reg_rdata[4:0] == ($past(dual) ? 5'h00 : 5'h01) && reg_rdata[14:10] == $past(k_eff) - 1);
  endproperty
  a_cfg: assert property (p_cfg) else $error("link parameter not minus one");

  property p_ila_plain;
    (start && tmode == TM_ILA && ila_first) |=> (lane0_data == 8'h1C && lane_k[0]);
  endproperty
  a_ila_plain: assert property (p_ila_plain) else $error("alignment data altered");

  property p_lane1_idle;
    !dual |=> (lane_valid[1] == 1'b0 && lane1_data == 8'h00);
  endproperty
  a_lane1_idle: assert property (p_lane1_idle) else $error("lane 1 used in single mode");

  property p_mf;
    sr_rise |=> (fc_q == 0) ##1 !multiframe_end;
  endproperty
  a_mf: assert property (p_mf) else $error("SYSREF did not realign");

endmodule : adc_cal_and_jesd_transport

// ==== adc_link_consts.svh ====
// Register map, field positions, reset values and timing counts of the channel output path
`ifndef ADC_LINK_CONSTS_SVH
`define ADC_LINK_CONSTS_SVH

// ==========================================
// Register offsets (byte addresses)
`define ADDR_CTRL        8'h00
`define ADDR_KCFG        8'h04
`define ADDR_STATUS      8'h08
`define ADDR_PARAMS      8'h0C
`define ADDR_RAMP        8'h10

// ==========================================
// Control register fields
`define CTRL_PD          0
`define CTRL_OFFBIN      1
`define CTRL_DUAL        2
`define CTRL_SCR         3
`define CTRL_SC1         4
`define CTRL_TM_LO       5
`define CTRL_TM_HI       7
`define CTRL_DIV_LO      8
`define CTRL_DIV_HI      9
`define CTRL_RST         10'h010
`define KCFG_RST         6'h20
`define RAMP_RST         16'h0001

// ==========================================
// Link status fields
`define STAT_CAL_DONE    0
`define STAT_CAL_BUSY    1
`define STAT_POR_WAIT    2

// ==========================================
// Frame length limits and fixed link values
`define K_MIN_SINGLE     6'h09
`define K_MIN_DUAL       6'h11
`define K_MAX            6'h20
`define RESOLUTION       16
`define SUBCLASS         1

// ==========================================
// Calibration timing in sampling clock cycles
`define POR_CYCLES       8400000
`define CAL_CYCLES       2000000

// ==========================================
// Control characters and test octets
`define OCT_D21_5        8'hB5
`define OCT_K28_5        8'hBC
`define OCT_K28_0        8'h1C
`define OCT_K28_3        8'h7C
`define SIGN_FLIP        16'h8000
`define PRBS_SEED        23'h7FFFFF
`define SCR_SEED         15'h7FFF

`endif

// ==== adc_link_pkg.sv ====
// Types shared by the channel output path modules
package adc_link_pkg;

  typedef logic [7:0]  addr_t;
  typedef logic [31:0] word_t;

  typedef enum logic [3:0] {
    ST_WAIT = 4'b0001,
    ST_CAL  = 4'b0010,
    ST_RUN  = 4'b0100,
    ST_DOWN = 4'b1000
  } cal_state_e;

  typedef enum logic [2:0] {
    TM_NORMAL = 3'h0,
    TM_D21_5  = 3'h1,
    TM_K28_5  = 3'h2,
    TM_ILA    = 3'h3,
    TM_RAMP   = 3'h4,
    TM_PRBS7  = 3'h5,
    TM_PRBS23 = 3'h6
  } test_mode_e;

endpackage : adc_link_pkg

// ==== cal_if.sv ====
// Handshake between the register side and the calibration sequencer
`timescale 1ns/1ps
interface cal_if;
  logic power_down;
  logic clk_ok;
  logic cal_done;
  logic cal_busy;
  logic por_wait;

  modport ctrl (output power_down, output clk_ok, input cal_done, input cal_busy,
                input por_wait);
  modport seq  (input power_down, input clk_ok, output cal_done, output cal_busy,
                output por_wait);
endinterface : cal_if

// ==== cal_seq.sv ====
// Converter core calibration sequencer: power-up delay, automatic and manual runs
`timescale 1ns/1ps
`include "adc_link_consts.svh"
module cal_seq #(
  parameter int POR_CYCLES = `POR_CYCLES,
  parameter int CAL_CYCLES = `CAL_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control side
  cal_if.seq       cal
);
  import adc_link_pkg::*;

  localparam logic [23:0] POR_LAST = 24'(POR_CYCLES - 1);
  localparam logic [23:0] CAL_LAST = 24'(CAL_CYCLES - 1);

  cal_state_e  st_q, st_d;
  logic [23:0] cnt_q, cnt_d;
  logic        done_q, done_d;

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q + 24'h000001;
    done_d = done_q;
    case (st_q)
      ST_WAIT: begin
        if (!cal.clk_ok) begin
          cnt_d = 24'h000000;
        end else if (cnt_q == POR_LAST) begin
          st_d  = ST_CAL;
          cnt_d = 24'h000000;
        end
      end
      ST_CAL: begin
        if (cal.power_down) begin
          st_d = ST_DOWN;
        end else if (cnt_q == CAL_LAST) begin
          st_d   = ST_RUN;
          done_d = 1'b1;
        end
      end
      ST_RUN: begin
        if (cal.power_down) begin
          st_d = ST_DOWN;
        end
      end
      ST_DOWN: begin
        // Leaving power-down reruns the calibration
        cnt_d = 24'h000000;
        if (!cal.power_down) begin
          st_d   = ST_CAL;
          done_d = 1'b0;
        end
      end
      default: begin
        st_d  = ST_WAIT;
        cnt_d = 24'h000000;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q   <= ST_WAIT;
      cnt_q  <= 24'h000000;
      done_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      done_q <= done_d;
    end
  end

  assign cal.cal_done = done_q;
  assign cal.cal_busy = (st_q == ST_CAL);
  assign cal.por_wait = (st_q == ST_WAIT);

  // ==========================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_cal_start;
    (st_q != ST_CAL) ##1 (st_q == ST_CAL);
  endsequence

  property p_done_clear;
    s_cal_start |-> !cal.cal_done;
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("done set at cal start");

  property p_por_to_cal;
    (st_q == ST_WAIT && cal.clk_ok && cnt_q == POR_LAST) |=> (st_q == ST_CAL && cnt_q == 0);
  endproperty
  a_por_to_cal: assert property (p_por_to_cal) else $error("power-up delay end missed");

  property p_por_hold;
    (st_q == ST_WAIT && !cal.clk_ok) |=> (st_q == ST_WAIT && cnt_q == 0);
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("delay ran without valid clock");

  property p_cal_len;
    $rose(cal.cal_done) |-> ($past(cnt_q) == CAL_LAST && $past(st_q) == ST_CAL);
  endproperty
  a_cal_len: assert property (p_cal_len) else $error("calibration length wrong");

  property p_recal;
    (st_q == ST_DOWN && !cal.power_down) |=> (st_q == ST_CAL && !cal.cal_done);
  endproperty
  a_recal: assert property (p_recal) else $error("no recalibration after power-down");

endmodule : cal_seq

// ==== jesd_rx_model.sv ====
// Behavioural lane receiver that rebuilds samples and frame counts from the lanes
`timescale 1ns/1ps
module jesd_rx_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Lane side
  input  wire logic [7:0]  lane0_data,
  input  wire logic [7:0]  lane1_data,
  input  wire logic [1:0]  lane_k,
  input  wire logic [1:0]  lane_valid,
  input  wire logic        frame_end,
  input  wire logic        multiframe_end,
  // Receiver view
  input  wire logic        dual,
  output      logic [15:0] rx_sample,
  output      logic [15:0] rx_prev,
  output      logic [7:0]  last_oct,
  output      logic        last_k,
  output      logic        lane_err,
  output      logic [31:0] n_oct,
  output      logic [31:0] mf_frames
);
  logic [7:0]  hi_q;
  logic [31:0] fcnt_q;

  // ==========================================
  // Reassembly
  // Only receives: no sync request goes back, so the link never stalls here
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      {rx_sample, rx_prev, last_oct, last_k, lane_err, hi_q} <= '0;
      {n_oct, mf_frames, fcnt_q} <= '0;
    end else begin
      if (lane_valid[0]) begin
        n_oct    <= n_oct + 32'h1;
        last_oct <= lane0_data;
        last_k   <= lane_k[0];
      end
      if (lane_valid[1] && !dual) lane_err <= 1'b1;
      if (dual && lane_valid == 2'b11) begin
        rx_prev   <= rx_sample;
        rx_sample <= {lane0_data, lane1_data};
      end else if (!dual && lane_valid[0] && !frame_end) begin
        hi_q <= lane0_data;
      end else if (!dual && lane_valid[0]) begin
        rx_prev   <= rx_sample;
        rx_sample <= {hi_q, lane0_data};
      end
      if (frame_end) fcnt_q <= multiframe_end ? 32'h0 : fcnt_q + 32'h1;
      if (multiframe_end) mf_frames <= fcnt_q + 32'h1;
    end
  end
endmodule : jesd_rx_model

// ==== tb_top.sv ====
// Self-checking bench for the channel output path with a lane receiver model
`timescale 1ns/1ps
`include "adc_link_consts.svh"
module tb_top;
  import adc_link_pkg::*;
  localparam int POR = 50;
  localparam int CAL = 20;
  logic        clk, rst_n, reg_wr, reg_rd, clk_ok, sample_valid, sysref, dual;
  addr_t       reg_addr;
  word_t       reg_wdata, reg_rdata, d, rv;
  logic [15:0] sample_in, rx_sample, rx_prev, smp;
  logic [7:0]  lane0_data, lane1_data, last_oct;
  logic [1:0]  lane_k, lane_valid, clock_divide_factor;
  logic        frame_end, multiframe_end, last_k, lane_err;
  logic [31:0] n_oct, mf_frames, seed;
  logic [5:0]  kc;
  logic [15:0] corner [4] = '{16'h8000, 16'h7FFF, 16'h0000, 16'hFFFF};
  logic [6:0]  mf_tab [3] = '{{1'b0, 6'h03}, {1'b1, 6'h03}, {1'b1, 6'h3F}};
  int          errors, n_tests, cyc, t0, el;

  adc_cal_and_jesd_transport #(.POR_CYCLES(POR), .CAL_CYCLES(CAL)) u_adc_cal_and_jesd_transport (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .clk_ok(clk_ok), .sample_in(sample_in),
    .sample_valid(sample_valid), .sysref(sysref), .lane0_data(lane0_data),
    .lane1_data(lane1_data), .lane_k(lane_k), .lane_valid(lane_valid), .frame_end(frame_end),
    .multiframe_end(multiframe_end), .clock_divide_factor(clock_divide_factor));

  jesd_rx_model u_jesd_rx_model (
    .clk(clk), .rst_n(rst_n), .lane0_data(lane0_data), .lane1_data(lane1_data),
    .lane_k(lane_k), .lane_valid(lane_valid), .frame_end(frame_end),
    .multiframe_end(multiframe_end), .dual(dual), .rx_sample(rx_sample), .rx_prev(rx_prev),
    .last_oct(last_oct), .last_k(last_k), .lane_err(lane_err), .n_oct(n_oct),
    .mf_frames(mf_frames));

  // ==========================================
  // Expectations
  function automatic word_t xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic word_t ctrl(logic pd, logic ob, logic dl, logic [2:0] tm, logic [1:0] dv);
    return {22'h0, dv, tm, 1'b1, 1'b0, dl, ob, pd};
  endfunction : ctrl

  function automatic logic [5:0] kclamp(logic dl, logic [5:0] k);
    logic [5:0] lo;
    lo = dl ? 6'h11 : 6'h09;
    return (k < lo) ? lo : ((k > 6'h20) ? 6'h20 : k);
  endfunction : kclamp

  function automatic word_t pexp(logic dl, logic [5:0] k);
    logic [5:0] km;
    km = k - 6'h1;
    return {1'b0, dl, 5'h00, 5'h0F, 5'h0F, km[4:0], 4'h0, dl, 4'h0, !dl};
  endfunction : pexp

  // First scrambled octet of a lane, 1 + x^14 + x^15 from the seed, MSB first
  function automatic logic [7:0] scr_exp(logic [7:0] v);
    logic [14:0] r;
    r = `SCR_SEED;
    for (int i = 7; i >= 0; i--) begin
      v[i] = v[i] ^ r[14] ^ r[13];
      r    = {r[13:0], v[i]};
    end
    return v;
  endfunction : scr_exp

  // ==========================================
  // Bus and check tasks
  task automatic chk(input word_t got, input word_t exp, input string m);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t ns: %s", $time, m);
    end
  endtask : chk

  task automatic wr(input addr_t a, input word_t v);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input addr_t a, output word_t v);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    v = reg_rdata;
    @(posedge clk);
  endtask : rd

  task automatic rd_chk(input addr_t a, input word_t exp, input string m);
    rd(a, d);
    chk(d, exp, m);
  endtask : rd_chk

  task automatic wait_done(input int start);
    d = '0;
    for (int n = 0; n < 300; n++) begin
      rd(`ADDR_STATUS, d);
      if (d[0] === 1'b1) break;
    end
    el = cyc - start;
  endtask : wait_done

  task automatic send(input logic [15:0] s, input logic [15:0] exp);
    sample_in    <= s;
    sample_valid <= 1'b1;
    @(posedge clk);
    sample_valid <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({16'h0, rx_sample}, {16'h0, exp}, "received sample");
    @(posedge clk);
  endtask : send

  task automatic end_of_test();
    if (errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  // ==========================================
  // Clock, cycle count and watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(negedge clk) cyc++;

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    end_of_test();
  end

  // ==========================================
  // Main sequence
  initial begin
    {rst_n, reg_wr, reg_rd, clk_ok, sample_valid, sysref, dual} = '0;
    reg_addr = '0; reg_wdata = '0; sample_in = '0;
    seed = 32'h3813FB13;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd_chk(`ADDR_CTRL, 32'h0000_0010, "control reset value");
    rd_chk(`ADDR_KCFG, 32'h0000_0020, "frame count reset value");
    rd_chk(`ADDR_RAMP, 32'h0000_0001, "ramp step reset value");
    wr(`ADDR_PARAMS, 32'hFFFF_FFFF);
    rd_chk(`ADDR_PARAMS, pexp(1'b0, 6'h20), "link parameters");
    wr(8'h14, 32'hFFFF_FFFF);
    rd_chk(8'h14, 32'h0, "unmapped address");
    // Clock not yet valid: no calibration may start however long we wait
    repeat (POR + 10) @(posedge clk);
    rd(`ADDR_STATUS, d);
    chk(d & 32'h7, 32'h4, "calibration before clock valid");
    clk_ok <= 1'b1;
    t0 = cyc;
    wait_done(t0);
    chk({31'h0, el >= POR + CAL && el <= POR + CAL + 8}, 32'h1, "power-up calibration time");
    wr(`ADDR_CTRL, ctrl(1'b1, 1'b0, 1'b0, 3'h0, 2'h1));
    wr(`ADDR_CTRL, ctrl(1'b0, 1'b0, 1'b0, 3'h0, 2'h1));
    t0 = cyc;
    rd(`ADDR_STATUS, d);
    chk(d & 32'h3, 32'h2, "manual run busy, done cleared");
    chk({30'h0, clock_divide_factor}, 32'h1, "clock divide output");
    wait_done(t0);
    chk({31'h0, el >= CAL && el <= CAL + 6}, 32'h1, "manual calibration time");
    // Divide back to 1 changes the rate: recalibrate, then wait instead of polling
    wr(`ADDR_CTRL, ctrl(1'b1, 1'b0, 1'b0, 3'h0, 2'h0));
    wr(`ADDR_CTRL, ctrl(1'b0, 1'b0, 1'b0, 3'h0, 2'h0));
    repeat (CAL * 5 / 4) @(posedge clk);
    rd(`ADDR_STATUS, d);
    chk(d & 32'h7, 32'h1, "done after fixed wait");
    // Formatting and lane mapping, corner values first
    for (int i = 0; i < 24; i++) begin
      dual <= i[0];
      wr(`ADDR_CTRL, ctrl(1'b0, i[1], i[0], 3'h0, 2'h0));
      rv = xs();
      smp = (i < 4) ? corner[i] : rv[15:0];
      send(smp, i[1] ? smp ^ `SIGN_FLIP : smp);
    end
    chk({31'h0, lane_err}, 32'h0, "second lane used in single mode");
    // Scrambled dual-lane sample: both lane scramblers still hold their seed
    dual <= 1'b1;
    wr(`ADDR_CTRL, ctrl(1'b0, 1'b0, 1'b1, 3'h0, 2'h0) | (32'h1 << `CTRL_SCR));
    rv = xs();
    send(rv[15:0], {scr_exp(rv[15:8]), scr_exp(rv[7:0])});
    // Test sequences keep the lanes busy; D21.5 and K28.5 octets checked by value
    dual <= 1'b0;
    for (int m = 1; m < 7; m++) begin
      wr(`ADDR_CTRL, ctrl(1'b0, 1'b0, 1'b0, m[2:0], 2'h0));
      rv = n_oct;
      repeat (8) @(posedge clk);
      @(negedge clk);
      chk({31'h0, n_oct - rv >= 32'h6}, 32'h1, "test sequence output");
      if (m < 3) chk({23'h0, last_k, last_oct}, m == 1 ? 32'h0B5 : 32'h1BC, "test octet");
      @(posedge clk);
    end
    rv = xs();
    wr(`ADDR_RAMP, {16'h0, rv[15:8], rv[7:0] | 8'h01});
    wr(`ADDR_CTRL, ctrl(1'b0, 1'b0, 1'b0, 3'h4, 2'h0));
    repeat (10) @(posedge clk);
    @(negedge clk);
    smp = rx_sample - rx_prev;
    chk({16'h0, smp}, {16'h0, rv[15:8], rv[7:0] | 8'h01}, "ramp step");
    @(posedge clk);
    // Frames per multiframe at both clamp limits
    for (int j = 0; j < 3; j++) begin
      dual <= mf_tab[j][6];
      kc = kclamp(mf_tab[j][6], mf_tab[j][5:0]);
      wr(`ADDR_KCFG, {26'h0, mf_tab[j][5:0]});
      wr(`ADDR_CTRL, ctrl(1'b0, 1'b0, mf_tab[j][6], 3'h1, 2'h0));
      rd_chk(`ADDR_KCFG, {26'h0, kc}, "clamped frame count");
      rd_chk(`ADDR_PARAMS, pexp(mf_tab[j][6], kc), "link parameters");
      repeat (int'(kc) * 6 + 8) @(posedge clk);
      @(negedge clk);
      chk(mf_frames, {26'h0, kc}, "frames per multiframe");
      @(posedge clk);
    end
    // One-shot SYSREF edge restarts the multiframe, which then ends K frames later
    sysref <= 1'b1;
    repeat (int'(kc) + 1) @(posedge clk);
    @(negedge clk);
    chk({31'h0, multiframe_end}, 32'h1, "multiframe realigned by SYSREF");
    @(posedge clk);
    sysref <= 1'b0;
    // Power-down silences the lanes
    wr(`ADDR_CTRL, ctrl(1'b1, 1'b0, 1'b0, 3'h1, 2'h0));
    @(negedge clk);
    rv = n_oct;
    repeat (10) @(negedge clk);
    chk(n_oct, rv, "output during power-down");
    @(posedge clk);
    end_of_test();
  end
endmodule : tb_top
